/* File: inc/mmu_pkg.sv */
// constants, types and helpers shared by the space-select and statistics logic
package mmu_pkg;
    localparam int IDX_W = 6;
    localparam int BASE_W = 12;
    localparam int PHYS_W = 18;
    localparam logic [11:0] DESC_REGION = 12'h000;
    localparam logic [11:0] BASE_REGION = 12'h100;
    localparam logic [11:0] STATUS_OFF = 12'h200;
    localparam logic [11:0] SPACE_OFF = 12'h204;
    localparam int KEY_LSB = 0;
    localparam int ED_BIT = 3;
    localparam int WRITTEN_BIT = 6;
    localparam int ATTN_BIT = 7;
    localparam int EN_BIT = 0;
    localparam int CAP_PAGE_LSB = 1;
    localparam int CAP_SPACE_BIT = 4;
    localparam int CAP_MODE_LSB = 5;
    localparam int TRAP_EN_BIT = 9;
    localparam int TRAP_FLAG_BIT = 12;
    localparam logic [15:0] DESC_RESET = 16'h0000;
    localparam logic [BASE_W-1:0] BASE_RESET = 12'h000;
    localparam logic [2:0] SPACE_RESET = 3'h0;
    localparam logic [2:0] KEY_RO_TRAP = 3'h1;
    localparam logic [2:0] KEY_RO = 3'h2;
    localparam logic [2:0] KEY_RW_TRAP = 3'h4;
    localparam logic [2:0] KEY_RW_WTRAP = 3'h5;
    localparam logic [2:0] KEY_RW = 3'h6;
    localparam logic [2:0] AMODE_IMM = 3'h2;
    localparam logic [2:0] AMODE_ABS = 3'h3;
    localparam logic [2:0] AMODE_IDX = 3'h6;
    localparam logic [2:0] AMODE_IDXD = 3'h7;
    localparam logic [2:0] PC_REG = 3'h7;
    localparam logic [1:0] CPU_KERNEL = 2'h0;
    localparam logic [1:0] CPU_SUPER = 2'h1;
    localparam logic [1:0] CPU_USER = 2'h3;

    typedef enum logic [1:0] {KIND_FETCH, KIND_EXT, KIND_INDIRECT, KIND_DATA} kind_type;

    typedef struct packed {
        logic abort;
        logic trap;
    } check_type;

    // key sits in the low bits so a descriptor increment steps the key
    function automatic check_type key_check(input logic [2:0] key, input logic wr);
        check_type c;
        c.abort = 1'b1;
        c.trap = 1'b0;
        case (key)
            KEY_RO_TRAP: begin c.abort = wr; c.trap = ~wr; end
            KEY_RO: c.abort = wr;
            KEY_RW_TRAP: begin c.abort = 1'b0; c.trap = 1'b1; end
            KEY_RW_WTRAP: begin c.abort = 1'b0; c.trap = wr; end
            KEY_RW: c.abort = 1'b0;
            default: c.abort = 1'b1;
        endcase
        return c;
    endfunction : key_check

    function automatic logic [PHYS_W-1:0] relocate(input logic [BASE_W-1:0] base, input logic [15:0] va);
        return {base, 6'h00} + {5'h00, va[12:0]};
    endfunction : relocate
endpackage : mmu_pkg

/* File: inc/ref_lookup_if.sv */
// reference attributes travelling between the top and the space selector
`timescale 1ns/1ns
`default_nettype none
interface ref_lookup_if;
    import mmu_pkg::*;
    logic [1:0] cpu_mode;
    kind_type kind;
    logic [2:0] addr_mode;
    logic [2:0] reg_num;
    logic [15:0] vaddr;
    logic [2:0] d_enable;
    logic use_d;
    logic [IDX_W-1:0] index;
    modport sel (input cpu_mode, kind, addr_mode, reg_num, vaddr, d_enable, output use_d, index);
    modport user (output cpu_mode, kind, addr_mode, reg_num, vaddr, d_enable, input use_d, index);
endinterface : ref_lookup_if
`default_nettype wire

/* File: design/space_select.sv */
// picks instruction or data space and the descriptor slot for a reference
`timescale 1ns/1ns
`default_nettype none
module space_select
    import mmu_pkg::*;
(
    ref_lookup_if.sel lk
);
    logic d_on;
    logic i_ext;

    always_comb begin
        // enable bit per mode: user bit 0, supervisor bit 1, kernel bit 2
        case (lk.cpu_mode)
            CPU_USER: d_on = lk.d_enable[0]; // [RULE20]
            CPU_SUPER: d_on = lk.d_enable[1];
            CPU_KERNEL: d_on = lk.d_enable[2];
            default: d_on = 1'b0;
        endcase
        i_ext = (lk.reg_num == PC_REG && (lk.addr_mode == AMODE_IMM || lk.addr_mode == AMODE_ABS))
            || lk.addr_mode == AMODE_IDX || lk.addr_mode == AMODE_IDXD;
        case (lk.kind)
            KIND_FETCH: lk.use_d = 1'b0; // [RULE10]
            KIND_EXT: lk.use_d = d_on & ~i_ext; // [RULE10]
            KIND_INDIRECT: lk.use_d = d_on; // [RULE11]
            KIND_DATA: lk.use_d = d_on; // [RULE11]
            default: lk.use_d = 1'b0;
        endcase
        // top three address bits choose one of eight sets per space
        lk.index = {lk.cpu_mode, lk.use_d, lk.vaddr[15:13]}; // [RULE19] [RULE9]
    end
endmodule : space_select
`default_nettype wire

/* File: design/trap_collector.sv */
// holds key-raised trap requests until the instruction ends; latches status once
`timescale 1ns/1ns
`default_nettype none
module trap_collector
    import mmu_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hit,
    input wire logic [IDX_W-1:0] hit_info,
    input wire logic instr_end,
    input wire logic sw_clear,
    output logic trap_req,
    output logic captured,
    output logic [IDX_W-1:0] cap_info
);
    logic pending;
    logic next_pending;
    logic next_trap_req;
    logic next_captured;
    logic [IDX_W-1:0] next_cap_info;

    always_comb begin
        next_trap_req = instr_end & (pending | hit); // [RULE21] [RULE1]
        next_pending = instr_end ? 1'b0 : (pending | hit); // [RULE21]
        next_captured = captured;
        next_cap_info = cap_info;
        if (sw_clear) begin
            next_captured = 1'b0;
        end
        // a hit in the clearing cycle still latches: the set wins
        if (hit && (!captured || sw_clear)) begin
            next_captured = 1'b1; // [RULE4]
            next_cap_info = hit_info; // [RULE4]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pending <= 1'b0;
            trap_req <= 1'b0;
            captured <= 1'b0;
            cap_info <= '0;
        end else begin
            pending <= next_pending;
            trap_req <= next_trap_req;
            captured <= next_captured;
            cap_info <= next_cap_info;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    capture_hold_a: assert property (captured && !sw_clear |=> cap_info == $past(cap_info)) // [RULE4]
        else $error("latched status overwritten");
    single_trap_a: assert property (hit && !instr_end ##2 $rose(instr_end) |=> trap_req ##1 !trap_req) // [RULE21]
        else $error("held trap not delivered once at instruction end");
endmodule : trap_collector
`default_nettype wire

/* File: design/mmu_space_select_and_stats.sv */
// memory management space selection, key checks, page statistics and apb registers
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Operation
// [RULE1] with trap enable set, keys 1, 4, 5 request a trap at instruction end
// [RULE2] keys 1, 4, 5 set the used descriptor's attention flag regardless of enable
// [RULE3] attention flags set independently in every descriptor touched by one instruction
// [RULE4] status captured once per trap event, later hits do not overwrite
// [RULE5] software descriptor write clears attention and written, stores other fields
// [RULE6] access key is the low field of the descriptor word
// [RULE7] key 2 reads freely and aborts writes; key 1 also traps reads
// [RULE8] key 4 traps both, key 5 traps writes only, key 6 never traps
// [RULE9] eight instruction and eight data register pairs per mode
// [RULE10] fetches, immediates, absolutes, index words use instruction space
// [RULE11] data space disabled for a mode sends all its references to instruction space
// [RULE12] direct-transfer master addresses pass unrelocated and unchecked
// [RULE13] status bit 0 turns relocation on or off
// [RULE14] reset instruction clears relocation enable
// [RULE15] every reference is checked, instruction fetches included
// [RULE16] condition codes are not restored after an abort
// [RULE17] faulted status-word moves may leave altered condition codes
// [RULE18] software polls and clears attention flags for statistics
// [RULE19] top three virtual address bits pick the register set
// [RULE20] space enable bit 0 enables user data space
// [RULE21] trap requests held until instruction end, delivered as one trap
module mmu_space_select_and_stats
    import mmu_pkg::*;
#(
    parameter int PAGES = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_valid,
    input wire logic ref_write,
    input wire logic [15:0] ref_vaddr,
    input wire logic [1:0] ref_cpu_mode,
    input wire kind_type ref_kind,
    input wire logic [2:0] ref_addr_mode,
    input wire logic [2:0] ref_reg,
    input wire logic instr_end,
    input wire logic reset_instr,
    output logic ref_done,
    output logic ref_abort,
    output logic [PHYS_W-1:0] phys_addr,
    output logic trap_req,
    input wire logic dma_valid,
    input wire logic [PHYS_W-1:0] dma_addr,
    output logic [PHYS_W-1:0] mem_addr
);
    localparam int SLOTS = 1 << IDX_W;

    if (PAGES != 8) begin : bad_pages
        $error("only eight page sets per space are supported");
    end

    //////////////////////////////////////////////////////////////////////////
    // storage
    logic [15:0] desc [SLOTS];
    logic [BASE_W-1:0] base [SLOTS];
    logic [15:0] next_desc [SLOTS];
    logic [BASE_W-1:0] next_base [SLOTS];
    logic reloc_en;
    logic trap_en;
    logic [2:0] d_enable;
    logic next_reloc_en;
    logic next_trap_en;
    logic [2:0] next_d_enable;
    logic next_ref_done;
    logic next_ref_abort;
    logic [PHYS_W-1:0] next_phys_addr;
    logic [31:0] next_prdata;

    //////////////////////////////////////////////////////////////////////////
    // space selection
    ref_lookup_if lk ();

    assign lk.cpu_mode = ref_cpu_mode;
    assign lk.kind = ref_kind;
    assign lk.addr_mode = ref_addr_mode;
    assign lk.reg_num = ref_reg;
    assign lk.vaddr = ref_vaddr;
    assign lk.d_enable = d_enable;

    space_select u_select (
        .lk(lk)
    );

    //////////////////////////////////////////////////////////////////////////
    // key check on the selected descriptor
    logic [15:0] cur_desc;
    check_type chk;
    logic checked;
    logic hit;
    logic captured;
    logic [IDX_W-1:0] cap_info;
    logic sw_clear;

    always_comb begin
        cur_desc = desc[lk.index];
        chk = key_check(cur_desc[KEY_LSB +: 3], ref_write); // [RULE6] [RULE7] [RULE8]
        // fetches are checked like any other reference
        checked = ref_valid & reloc_en; // [RULE15]
        hit = checked & chk.trap & trap_en; // [RULE1]
    end

    //////////////////////////////////////////////////////////////////////////
    // apb decode
    logic setup_ph;
    logic wr_acc;
    logic in_desc;
    logic in_base;
    logic is_status;
    logic is_space;
    logic mapped;
    logic [IDX_W-1:0] reg_idx;
    logic [31:0] rd_value;

    always_comb begin
        setup_ph = psel & ~penable;
        in_desc = paddr[11:8] == DESC_REGION[11:8];
        in_base = paddr[11:8] == BASE_REGION[11:8];
        is_status = paddr == STATUS_OFF;
        is_space = paddr == SPACE_OFF;
        mapped = (in_desc | in_base | is_status | is_space) & (paddr[1:0] == 2'h0);
        wr_acc = psel & penable & pwrite & mapped;
        reg_idx = paddr[IDX_W+1:2];
        sw_clear = wr_acc & is_status & pwdata[TRAP_FLAG_BIT];
        pready = 1'b1;
        pslverr = psel & penable & ~mapped;
        rd_value = 32'h0000_0000;
        if (in_desc) begin
            rd_value[15:0] = desc[reg_idx];
        end else if (in_base) begin
            rd_value[BASE_W-1:0] = base[reg_idx];
        end else if (is_status) begin
            rd_value[EN_BIT] = reloc_en;
            rd_value[CAP_PAGE_LSB +: 3] = cap_info[2:0];
            rd_value[CAP_SPACE_BIT] = cap_info[3];
            rd_value[CAP_MODE_LSB +: 2] = cap_info[5:4];
            rd_value[TRAP_EN_BIT] = trap_en;
            rd_value[TRAP_FLAG_BIT] = captured;
        end else if (is_space) begin
            rd_value[2:0] = d_enable;
        end
        if (!mapped) begin
            rd_value = 32'h0000_0000;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_desc = desc;
        next_base = base;
        next_reloc_en = reloc_en;
        next_trap_en = trap_en;
        next_d_enable = d_enable;
        next_prdata = setup_ph ? rd_value : prdata;
        if (wr_acc && in_desc) begin
            next_desc[reg_idx] = pwdata[15:0];
            next_desc[reg_idx][ATTN_BIT] = 1'b0; // [RULE5]
            next_desc[reg_idx][WRITTEN_BIT] = 1'b0; // [RULE5]
        end
        if (wr_acc && in_base) begin
            next_base[reg_idx] = pwdata[BASE_W-1:0];
        end
        if (wr_acc && is_status) begin
            next_reloc_en = pwdata[EN_BIT]; // [RULE13]
            next_trap_en = pwdata[TRAP_EN_BIT];
        end
        if (wr_acc && is_space) begin
            next_d_enable = pwdata[2:0]; // [RULE20]
        end
        // the reset instruction falls back to direct addressing
        if (reset_instr) begin
            next_reloc_en = 1'b0; // [RULE14]
        end
        // hardware flag updates come after the software write: the set wins
        if (checked && chk.trap) begin
            next_desc[lk.index][ATTN_BIT] = 1'b1; // [RULE2] [RULE3]
        end
        if (checked && ref_write && !chk.abort) begin
            next_desc[lk.index][WRITTEN_BIT] = 1'b1;
        end
        next_ref_done = ref_valid;
        // aborts leave condition codes to the core; no rollback here
        next_ref_abort = checked & chk.abort; // [RULE15] [RULE16] [RULE17]
        next_phys_addr = reloc_en ? relocate(base[lk.index], ref_vaddr) : {2'h0, ref_vaddr}; // [RULE13]
        if (!ref_valid) begin
            next_phys_addr = phys_addr;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < SLOTS; i++) begin
                desc[i] <= DESC_RESET;
                base[i] <= BASE_RESET;
            end
            reloc_en <= 1'b0;
            trap_en <= 1'b0;
            d_enable <= SPACE_RESET;
            prdata <= 32'h0000_0000;
            ref_done <= 1'b0;
            ref_abort <= 1'b0;
            phys_addr <= '0;
        end else begin
            desc <= next_desc;
            base <= next_base;
            reloc_en <= next_reloc_en;
            trap_en <= next_trap_en;
            d_enable <= next_d_enable;
            prdata <= next_prdata;
            ref_done <= next_ref_done;
            ref_abort <= next_ref_abort;
            phys_addr <= next_phys_addr;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // trap gathering
    trap_collector u_traps (
        .core_clk(core_clk),
        .reset(reset),
        .hit(hit),
        .hit_info(lk.index),
        .instr_end(instr_end),
        .sw_clear(sw_clear),
        .trap_req(trap_req),
        .captured(captured),
        .cap_info(cap_info)
    );

    // direct-transfer masters bypass relocation and key checks entirely
    assign mem_addr = dma_valid ? dma_addr : phys_addr; // [RULE12]

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence mapped_ref_s(logic [2:0] k, logic w);
        ref_valid && reloc_en && cur_desc[2:0] == k && ref_write == w;
    endsequence

    sequence done_s(logic ab);
        ref_done && ref_abort == ab;
    endsequence

    key2_write_a: assert property (mapped_ref_s(KEY_RO, 1'b1) |=> done_s(1'b1)) // [RULE7]
        else $error("key 2 write not aborted");
    key1_read_a: assert property (mapped_ref_s(KEY_RO_TRAP, 1'b0) ##0 (trap_en && !instr_end)
        ##2 $rose(instr_end) |=> trap_req) // [RULE7]
        else $error("key 1 read did not trap");
    key6_clean_a: assert property (mapped_ref_s(KEY_RW, 1'b1) |-> !hit ##1 done_s(1'b0)) // [RULE8]
        else $error("key 6 write trapped or aborted");
    key5_read_a: assert property (mapped_ref_s(KEY_RW_WTRAP, 1'b0) |-> !hit ##1 done_s(1'b0)) // [RULE8]
        else $error("key 5 read trapped");
    attention_set_a: assert property (ref_valid && reloc_en && chk.trap
        |=> desc[$past(lk.index)][ATTN_BIT]) // [RULE2]
        else $error("attention flag not set");
    desc_clear_a: assert property (wr_acc && in_desc && !(checked && lk.index == reg_idx)
        |=> !desc[$past(reg_idx)][ATTN_BIT] && !desc[$past(reg_idx)][WRITTEN_BIT]
        && desc[$past(reg_idx)][2:0] == $past(pwdata[2:0])) // [RULE5]
        else $error("descriptor write did not clear flags");
    direct_addr_a: assert property (ref_valid && !reloc_en |=> done_s(1'b0)
        ##0 phys_addr == {2'h0, $past(ref_vaddr)}) // [RULE13]
        else $error("unmapped reference altered");
    reset_instr_a: assert property (reset_instr |=> !reloc_en) // [RULE14]
        else $error("reset instruction left relocation on");
    dma_bypass_a: assert property (dma_valid |-> mem_addr == dma_addr) // [RULE12]
        else $error("direct transfer address relocated");
    page_pick_a: assert property (ref_valid |-> lk.index[2:0] == ref_vaddr[15:13]) // [RULE19]
        else $error("wrong page set selected");
    i_space_a: assert property (ref_valid && (ref_kind == KIND_FETCH
        || !d_enable[0] && ref_cpu_mode == CPU_USER) |-> !lk.use_d) // [RULE10]
        else $error("reference mapped through data space");
endmodule : mmu_space_select_and_stats
`default_nettype wire

/* File: test/core_model.sv */
// processor core stand-in: issues references and marks instruction boundaries
`timescale 1ns/1ns
`default_nettype none
module core_model
    import mmu_pkg::*;
(
    input wire logic core_clk,
    output logic ref_valid,
    output logic ref_write,
    output logic [15:0] ref_vaddr,
    output logic [1:0] ref_cpu_mode,
    output kind_type ref_kind,
    output logic [2:0] ref_addr_mode,
    output logic [2:0] ref_reg,
    output logic instr_end,
    output logic reset_instr,
    input wire logic ref_done,
    input wire logic ref_abort,
    input wire logic [PHYS_W-1:0] phys_addr,
    input wire logic trap_req
);
    initial begin
        ref_valid = 1'b0;
        ref_write = 1'b0;
        ref_vaddr = 16'h0000;
        ref_cpu_mode = 2'h0;
        ref_kind = KIND_FETCH;
        ref_addr_mode = 3'h0;
        ref_reg = 3'h0;
        instr_end = 1'b0;
        reset_instr = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic issue(input logic w, input logic [15:0] va, input logic [1:0] md, input kind_type kd,
        input logic [2:0] am, input logic [2:0] rg, output logic dn, output logic ab, output logic [PHYS_W-1:0] ph);
        @(posedge core_clk);
        ref_valid <= 1'b1;
        ref_write <= w;
        ref_vaddr <= va;
        ref_cpu_mode <= md;
        ref_kind <= kd;
        ref_addr_mode <= am;
        ref_reg <= rg;
        @(posedge core_clk);
        ref_valid <= 1'b0;
        // released address toggles so a stale value is never mistaken for a held one
        ref_vaddr <= ~va;
        #1;
        dn = ref_done;
        ab = ref_abort;
        ph = phys_addr;
    endtask : issue

    // trap is looked at in the cycle after the end pulse and once more after
    task automatic end_instr(output logic t1, output logic t2);
        @(posedge core_clk);
        instr_end <= 1'b1;
        @(posedge core_clk);
        instr_end <= 1'b0;
        #1;
        t1 = trap_req;
        @(posedge core_clk);
        #1;
        t2 = trap_req;
    endtask : end_instr

    task automatic rst_instr();
        @(posedge core_clk);
        reset_instr <= 1'b1;
        @(posedge core_clk);
        reset_instr <= 1'b0;
    endtask : rst_instr
endmodule : core_model
`default_nettype wire

/* File: test/mmu_space_select_and_stats_test.sv */
// self-checking bench for space selection, key checks and page statistics
`timescale 1ns/1ns
`default_nettype none
module mmu_space_select_and_stats_test;
    import mmu_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, ref_valid, ref_write, instr_end, reset_instr, ref_done, ref_abort, trap_req;
    logic [15:0] ref_vaddr;
    logic [1:0] ref_cpu_mode;
    kind_type ref_kind;
    logic [2:0] ref_addr_mode, ref_reg;
    logic dma_valid = 1'b0;
    logic [PHYS_W-1:0] dma_addr = 18'h00000;
    logic [PHYS_W-1:0] phys_addr, mem_addr, ph;
    logic er, dn, ab, t1, t2;
    int err_total = 0;
    int cmp_count = 0;

    always #2 core_clk = ~core_clk;

    mmu_space_select_and_stats #(.PAGES(8)) uut (.core_clk(core_clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_valid(ref_valid), .ref_write(ref_write), .ref_vaddr(ref_vaddr),
        .ref_cpu_mode(ref_cpu_mode), .ref_kind(ref_kind), .ref_addr_mode(ref_addr_mode), .ref_reg(ref_reg),
        .instr_end(instr_end), .reset_instr(reset_instr), .ref_done(ref_done), .ref_abort(ref_abort),
        .phys_addr(phys_addr), .trap_req(trap_req), .dma_valid(dma_valid), .dma_addr(dma_addr),
        .mem_addr(mem_addr));

    core_model core (.core_clk(core_clk), .ref_valid(ref_valid), .ref_write(ref_write), .ref_vaddr(ref_vaddr),
        .ref_cpu_mode(ref_cpu_mode), .ref_kind(ref_kind), .ref_addr_mode(ref_addr_mode), .ref_reg(ref_reg),
        .instr_end(instr_end), .reset_instr(reset_instr), .ref_done(ref_done), .ref_abort(ref_abort),
        .phys_addr(phys_addr), .trap_req(trap_req));
    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk

    function automatic logic [11:0] dsc(input logic [1:0] md, input logic dsp, input logic [2:0] pg);
        return DESC_REGION | {4'h0, md, dsp, pg, 2'h0};
    endfunction : dsc

    task automatic sp(input kind_type kd, input logic [2:0] am, input logic [2:0] rg, input logic dsp);
        core.issue(1'b0, 16'h6020, CPU_USER, kd, am, rg, dn, ab, ph);
        chk(ph, dsp ? 18'h08020 : 18'h04020);
    endtask : sp
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rchk(STATUS_OFF, 32'h0000_0000);
        rchk(SPACE_OFF, 32'h0000_0000);
        rchk(dsc(CPU_USER, 1'b1, 3'h7), 32'h0000_0000);
        apb(1'b0, 12'h300, 32'h0000_0000);
        chk({er, rd[30:0]}, {1'b1, 31'h0000_0000});
    endtask : t_reset

    task automatic t_keys();
        logic ok, trp;
        apb(1'b1, STATUS_OFF, 32'h0000_0201);
        apb(1'b1, BASE_REGION | dsc(CPU_KERNEL, 1'b0, 3'h1), 32'h0000_0040);
        for (int k = 0; k < 8; k++) begin
            for (int w = 0; w < 2; w++) begin
                ok = (k inside {1, 2, 4, 5, 6}) && !(w == 1 && k < 3);
                trp = (k == 4) || (k == 1 && w == 0) || (k == 5 && w == 1);
                apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h1), 32'(k));
                // reads go in as fetches so that fetches are checked too
                core.issue(w[0], 16'h2010, CPU_KERNEL, w ? KIND_DATA : KIND_FETCH, 3'h0, 3'h0, dn, ab, ph);
                chk({dn, ab}, {1'b1, !ok});
                if (ok) chk(ph, 18'h01010);
                core.end_instr(t1, t2);
                chk(t1, trp);
                rchk(dsc(CPU_KERNEL, 1'b0, 3'h1), 32'(k) | {trp, ok && w, 6'h00});
                if (trp) apb(1'b1, STATUS_OFF, 32'h0000_1201);
            end
        end
    endtask : t_keys

    task automatic t_stats();
        apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h2), 32'h0000_0004);
        apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h5), 32'h0000_0005);
        core.issue(1'b0, 16'h4000, CPU_KERNEL, KIND_DATA, 3'h1, 3'h0, dn, ab, ph);
        core.issue(1'b1, 16'hA002, CPU_KERNEL, KIND_DATA, 3'h1, 3'h1, dn, ab, ph);
        core.issue(1'b0, 16'h4004, CPU_KERNEL, KIND_DATA, 3'h1, 3'h0, dn, ab, ph);
        core.end_instr(t1, t2);
        chk({t1, t2}, 2'h2);
        rchk(STATUS_OFF, 32'h0000_1205);
        rchk(dsc(CPU_KERNEL, 1'b0, 3'h2), 32'h0000_0084);
        rchk(dsc(CPU_KERNEL, 1'b0, 3'h5), 32'h0000_00C5);
        apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h5), 32'h0000_FFC5);
        rchk(dsc(CPU_KERNEL, 1'b0, 3'h5), 32'h0000_FF05);
        // statistics by polling: trap enable left clear
        apb(1'b1, STATUS_OFF, 32'h0000_1001);
        apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h2), 32'h0000_0004);
        core.issue(1'b0, 16'h4000, CPU_KERNEL, KIND_DATA, 3'h1, 3'h0, dn, ab, ph);
        core.end_instr(t1, t2);
        chk(t1, 1'b0);
        rchk(dsc(CPU_KERNEL, 1'b0, 3'h2), 32'h0000_0084);
        apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h2), 32'h0000_0004);
        rchk(dsc(CPU_KERNEL, 1'b0, 3'h2), 32'h0000_0004);
    endtask : t_stats

    task automatic t_incr();
        apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h1), 32'h0000_0001);
        apb(1'b0, dsc(CPU_KERNEL, 1'b0, 3'h1), 32'h0000_0000);
        apb(1'b1, dsc(CPU_KERNEL, 1'b0, 3'h1), rd + 32'h1);
        rchk(dsc(CPU_KERNEL, 1'b0, 3'h1), 32'h0000_0002);
        core.issue(1'b1, 16'h2000, CPU_KERNEL, KIND_DATA, 3'h1, 3'h0, dn, ab, ph);
        chk(ab, 1'b1);
    endtask : t_incr

    task automatic t_space();
        apb(1'b1, dsc(CPU_USER, 1'b0, 3'h3), 32'h0000_0006);
        apb(1'b1, dsc(CPU_USER, 1'b1, 3'h3), 32'h0000_0006);
        apb(1'b1, BASE_REGION | dsc(CPU_USER, 1'b0, 3'h3), 32'h0000_0100);
        apb(1'b1, BASE_REGION | dsc(CPU_USER, 1'b1, 3'h3), 32'h0000_0200);
        sp(KIND_DATA, 3'h1, 3'h2, 1'b0);
        apb(1'b1, SPACE_OFF, 32'h0000_0001);
        sp(KIND_FETCH, 3'h0, 3'h0, 1'b0);
        sp(KIND_EXT, AMODE_IMM, PC_REG, 1'b0);
        sp(KIND_EXT, AMODE_ABS, PC_REG, 1'b0);
        sp(KIND_EXT, AMODE_IDX, 3'h2, 1'b0);
        sp(KIND_EXT, AMODE_IDXD, 3'h5, 1'b0);
        sp(KIND_INDIRECT, 3'h3, 3'h1, 1'b1);
        sp(KIND_DATA, 3'h1, 3'h2, 1'b1);
        core.issue(1'b0, 16'h8020, CPU_USER, KIND_DATA, 3'h1, 3'h2, dn, ab, ph);
        chk(ab, 1'b1);
    endtask : t_space

    task automatic t_direct();
        @(posedge core_clk);
        dma_valid <= 1'b1;
        dma_addr <= 18'h2ABCD;
        @(posedge core_clk);
        #1;
        chk(mem_addr, 18'h2ABCD);
        @(posedge core_clk);
        dma_valid <= 1'b0;
        core.rst_instr();
        apb(1'b0, STATUS_OFF, 32'h0000_0000);
        chk(rd[EN_BIT], 1'b0);
        core.issue(1'b1, 16'hE123, CPU_KERNEL, KIND_DATA, 3'h1, 3'h0, dn, ab, ph);
        chk({ab, ph}, {1'b0, 18'h0E123});
        chk(mem_addr, 18'h0E123);
        apb(1'b1, STATUS_OFF, 32'h0000_0001);
        core.issue(1'b1, 16'hE123, CPU_KERNEL, KIND_DATA, 3'h1, 3'h0, dn, ab, ph);
        chk(ab, 1'b1);
        apb(1'b1, STATUS_OFF, 32'h0000_0000);
        core.issue(1'b1, 16'hE123, CPU_KERNEL, KIND_DATA, 3'h1, 3'h0, dn, ab, ph);
        chk(ab, 1'b0);
    endtask : t_direct
    //////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_keys();
        t_stats();
        t_incr();
        t_space();
        t_direct();
        results();
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        results();
    end
endmodule : mmu_space_select_and_stats_test
`default_nettype wire
